//--- verilog/iet_regs.svh
`ifndef IET_REGS_SVH
`define IET_REGS_SVH
// Sizes and counts of the interrupt and event transfer block
`define IET_NODES     46
`define IET_NODE_W    6
`define IET_CHANS     8
`define IET_CHAN_W    3
`define IET_PRIO_W    4
`define IET_ADDR_W    24
`define IET_CNT_W     8
`define IET_SHARED    4
`define IET_SHARED_LO 42
`define IET_EXTRA     8
`define IET_SEL_W     3
`define IET_LAT_W     4
// Request to service start, in CPU clocks
`define IET_LAT_FAST  4'hB
`define IET_LAT_CACHE 4'h7
`define IET_LAT_PRE   4'h2
`define IET_STEP_BYTE 24'h000001
`define IET_STEP_WORD 24'h000002
`endif

//--- verilog/iet_pkg.sv
// Purpose: types shared by the interrupt and event transfer block
// Assumes: constants come from iet_regs.svh
// Notes:   none
`include "iet_regs.svh"
package iet_pkg;
    typedef struct packed {
        logic                    en;
        logic [`IET_PRIO_W-1:0]  prio;
        logic                    toEvt;
        logic [`IET_CHAN_W-1:0]  chan;
    } iet_node_cfg_t;

    typedef struct packed {
        logic [`IET_ADDR_W-1:0]  src;
        logic [`IET_ADDR_W-1:0]  dst;
        logic [`IET_CNT_W-1:0]   count;
        logic                    incSrc;
        logic                    incDst;
        logic                    isWord;
        logic                    contin;
    } iet_chan_t;

    typedef struct packed {
        logic [`IET_ADDR_W-1:0]  src;
        logic [`IET_ADDR_W-1:0]  dst;
        logic                    isWord;
    } iet_move_t;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SERVE} iet_state_t;
endpackage

//--- verilog/iet_ctrl.sv
// Purpose: interrupt arbitration and single-transfer event channels
// Assumes: request sources and CPU run on clk_sys; memory bus performs
//          the move in the cycle moveValid is high
// Notes:   one service in flight at a time
// How it works
// [R1] Each node routes to interrupt or event unit
// [R2] Interrupt service redirects CPU to node vector
// [R3] Event service stalls CPU exactly one cycle
// [R4] Event service moves one byte or word
// [R5] Pointers increment after transfer per configuration
// [R6] Counter decrements unless continuous mode set
// [R7] Counter reaching zero raises node's interrupt
// [R8] Eight channels, own pointers and counter
// [R9] Request to service: 7 or 11 clocks
// [R10] 46 nodes: flag, enable, priority each
// [R11] Select registers pick source of shared nodes
// [R12] Software set of flag equals hardware request
// [R13] Highest enabled pending priority served first
`include "iet_regs.svh"
module iet_ctrl (
    input  wire logic                            clk_sys,
    input  wire logic                            sys_rst,
    input  wire logic [`IET_NODES-1:0]           hwReq,
    input  wire logic [`IET_EXTRA-1:0]           extraReq,
    input  wire logic [`IET_SEL_W-1:0]           srcSel [`IET_SHARED],
    input  wire iet_pkg::iet_node_cfg_t          nodeCfg [`IET_NODES],
    input  wire logic [`IET_NODES-1:0]           swSetReq,
    input  wire logic                            jumpCacheUse,
    input  wire logic [`IET_CHANS-1:0]           chanLoad,
    input  wire iet_pkg::iet_chan_t              chanLoadCfg,
    output logic [`IET_NODES-1:0]                requestFlagBit,
    output logic                                 cpuStall,
    output logic                                 moveValid,
    output iet_pkg::iet_move_t                   move,
    output logic                                 irqTake,
    output logic [`IET_NODE_W-1:0]               irqNode,
    output iet_pkg::iet_chan_t                   chanState [`IET_CHANS],
    output logic                                 busy
);
    import iet_pkg::*;

    logic [`IET_NODES-1:0]   srcReq;
    logic [`IET_NODES-1:0]   flag_q, flag_d;
    iet_state_t              state_q, state_d;
    logic [`IET_LAT_W-1:0]   lat_q, lat_d;
    logic [`IET_NODE_W-1:0]  node_q, node_d;
    iet_move_t               move_q, move_d;
    iet_chan_t               chan_q [`IET_CHANS];
    iet_chan_t               chan_d [`IET_CHANS];
    logic                    anyPend;
    logic [`IET_NODE_W-1:0]  winner;
    logic                    srvEvt, srvXfer, srvIrq;
    iet_chan_t               curChan;
    logic [`IET_CNT_W-1:0]   cntNext;

    // Dedicated nodes pass straight; shared nodes take the selected source
    genvar g;
    generate
        for (g = 0; g < `IET_NODES; g++) begin : gNode
            if (g >= `IET_SHARED_LO) begin : gShared
                assign srcReq[g] = extraReq[srcSel[g-`IET_SHARED_LO]]; // see [R11]
            end else begin : gDirect
                assign srcReq[g] = hwReq[g];
            end
        end
    endgenerate

    // Ties go to the lowest node number
    function automatic logic [`IET_NODE_W:0] pickWinner(
        input logic [`IET_NODES-1:0] pend,
        input iet_node_cfg_t         cfg [`IET_NODES]
    );
        logic                    found;
        logic [`IET_NODE_W-1:0]  idx;
        logic [`IET_PRIO_W-1:0]  best;
        found = 1'b0;
        idx   = '0;
        best  = '0;
        for (int i = 0; i < `IET_NODES; i++) begin
            if (pend[i] && cfg[i].en && (!found || cfg[i].prio > best)) begin // see [R13]
                found = 1'b1;
                idx   = `IET_NODE_W'(i);
                best  = cfg[i].prio;
            end
        end
        return {found, idx};
    endfunction

    always_comb begin
        {anyPend, winner} = pickWinner(flag_q, nodeCfg);
    end

    assign curChan = chan_q[nodeCfg[node_q].chan];
    assign srvEvt  = (state_q == ST_SERVE) && nodeCfg[node_q].toEvt; // see [R1]
    // An exhausted, non-continuous channel hands over to the interrupt
    assign srvXfer = srvEvt && (curChan.contin || curChan.count != '0);
    assign cntNext = curChan.contin ? curChan.count
                                    : curChan.count - `IET_CNT_W'(1); // see [R6]
    assign srvIrq  = (state_q == ST_SERVE)
                     && (!srvXfer || (!curChan.contin && cntNext == '0)); // see [R7]

    // Request flags: set wins over the service clear
    always_comb begin
        flag_d = flag_q;
        if (state_q == ST_SERVE) begin
            flag_d[node_q] = 1'b0;
        end
        flag_d = flag_d | srcReq | swSetReq; // see [R10] see [R12]
    end

    always_comb begin
        state_d = state_q;
        lat_d   = lat_q;
        node_d  = node_q;
        move_d  = move_q;
        case (state_q)
            ST_IDLE: begin
                if (anyPend) begin
                    state_d = ST_WAIT;
                    node_d  = winner;
                    lat_d   = (jumpCacheUse ? `IET_LAT_CACHE : `IET_LAT_FAST)
                              - `IET_LAT_PRE; // see [R9]
                end
            end
            ST_WAIT: begin
                if (lat_q == '0) begin
                    state_d     = ST_SERVE;
                    move_d.src  = chan_q[nodeCfg[node_q].chan].src;
                    move_d.dst  = chan_q[nodeCfg[node_q].chan].dst;
                    move_d.isWord = chan_q[nodeCfg[node_q].chan].isWord; // see [R4]
                end else begin
                    lat_d = lat_q - `IET_LAT_W'(1);
                end
            end
            ST_SERVE: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Channel update; a software load in the same cycle wins
    always_comb begin
        logic [`IET_ADDR_W-1:0] step;
        step = curChan.isWord ? `IET_STEP_WORD : `IET_STEP_BYTE;
        for (int c = 0; c < `IET_CHANS; c++) begin
            chan_d[c] = chan_q[c]; // see [R8]
            if (chanLoad[c]) begin
                chan_d[c] = chanLoadCfg;
            end else if (srvXfer && nodeCfg[node_q].chan == `IET_CHAN_W'(c)) begin
                if (curChan.incSrc) begin
                    chan_d[c].src = curChan.src + step; // see [R5]
                end
                if (curChan.incDst) begin
                    chan_d[c].dst = curChan.dst + step; // see [R5]
                end
                chan_d[c].count = cntNext;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            flag_q  <= '0;
            state_q <= ST_IDLE;
            lat_q   <= '0;
            node_q  <= '0;
            move_q  <= '0;
            for (int c = 0; c < `IET_CHANS; c++) begin
                chan_q[c] <= '0;
            end
        end else begin
            flag_q  <= flag_d;
            state_q <= state_d;
            lat_q   <= lat_d;
            node_q  <= node_d;
            move_q  <= move_d;
            for (int c = 0; c < `IET_CHANS; c++) begin
                chan_q[c] <= chan_d[c];
            end
        end
    end

    assign requestFlagBit = flag_q;
    assign cpuStall       = srvXfer; // see [R3]
    assign moveValid      = srvXfer; // see [R4]
    assign move           = move_q;
    assign irqTake        = srvIrq;  // see [R2]
    assign irqNode        = node_q;
    assign busy           = (state_q != ST_IDLE);
    assign chanState      = chan_q;

    // Helper: cycles since the chosen node was latched
    logic [`IET_LAT_W-1:0] age_q, age_d;
    always_comb begin
        age_d = (state_q == ST_IDLE) ? '0 : age_q + `IET_LAT_W'(1);
    end
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            age_q <= '0;
        end else begin
            age_q <= age_d;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_lat_cache: assert property ( // see [R9]
        state_q == ST_IDLE && anyPend && jumpCacheUse |-> ##7 state_q == ST_SERVE)
        else $error("cached service not at 7 clocks");
    a_lat_plain: assert property ( // see [R9]
        state_q == ST_IDLE && anyPend && !jumpCacheUse
            |-> ##1 (state_q == ST_WAIT) [*5] ##1 (state_q == ST_WAIT) [*5]
                ##1 state_q == ST_SERVE)
        else $error("uncached service not at 11 clocks");
    a_stall_one: assert property ( // see [R3]
        cpuStall |=> !cpuStall)
        else $error("stall longer than one cycle");
    a_evt_route: assert property ( // see [R1]
        moveValid |-> nodeCfg[node_q].toEvt && state_q == ST_SERVE)
        else $error("transfer for an interrupt-routed node");
    a_cnt_dec: assert property ( // see [R6]
        srvXfer && !curChan.contin && chanLoad == '0
            |=> curChan.count == $past(curChan.count) - 8'h01)
        else $error("counter not decremented");
    a_ptr_inc: assert property ( // see [R5]
        srvXfer && curChan.incSrc && chanLoad == '0
            |=> curChan.src == $past(curChan.src)
                + ($past(curChan.isWord) ? `IET_STEP_WORD : `IET_STEP_BYTE))
        else $error("source pointer not stepped");
    a_zero_irq: assert property ( // see [R7]
        srvXfer && !curChan.contin && curChan.count == 8'h01 |-> irqTake)
        else $error("no interrupt on exhausted counter");
    a_std_irq: assert property ( // see [R2]
        state_q == ST_SERVE && !nodeCfg[node_q].toEvt |-> irqTake && !moveValid)
        else $error("interrupt service missing");
    a_sw_set: assert property ( // see [R12]
        swSetReq[5] |=> requestFlagBit[5])
        else $error("software set lost");
    a_prio_pick: assert property ( // see [R13]
        state_q == ST_IDLE && anyPend |-> nodeCfg[winner].en && flag_q[winner])
        else $error("winner not pending and enabled");
    a_serve_age: assert property ( // see [R9]
        state_q == ST_SERVE
            |-> age_q == `IET_LAT_CACHE - 4'h1 || age_q == `IET_LAT_FAST - 4'h1)
        else $error("service at wrong age");

    c_event_xfer: cover property (srvXfer && !irqTake);
    c_event_done: cover property (srvXfer && irqTake);
    c_plain_irq:  cover property (irqTake && !srvEvt);
    c_back2back:  cover property (irqTake ##1 state_q == ST_IDLE && anyPend);
endmodule

//--- sim/iet_src_model.sv
// Purpose: peripheral request sources and CPU side facing iet_ctrl
// Assumes: one clock; request lines change just after the rising edge
// Notes:   counts CPU cycles lost to event moves
`include "iet_regs.svh"
module iet_src_model (
    input  wire logic                  clk_sys,
    input  wire logic                  cpuStall,
    output logic [`IET_NODES-1:0]      hwReq,
    output int                         stallCount
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        hwReq = '0;
        stallCount = 0;
    end
    // One-cycle pulse, as a peripheral event line gives
    task automatic fire(input int i);
        @(posedge clk_sys);
        hwReq[i] <= 1'b1;
        @(posedge clk_sys);
        hwReq[i] <= 1'b0;
    endtask
    always @(posedge clk_sys) begin
        if (cpuStall === 1'b1) begin
            stallCount <= stallCount + 1;
        end
    end
endmodule

//--- sim/iet_ctrl_tb_top.sv
// Purpose: self-checking bench for iet_ctrl
// Assumes: 40 MHz clock; inputs driven on the rising edge
// Notes:   node 6 is left disabled and must stay pending
`include "iet_regs.svh"
module iet_ctrl_tb_top import iet_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   clk_sys = 1'b0;
    logic                   sys_rst = 1'b1;
    logic [`IET_NODES-1:0]  hwReq;
    logic [`IET_EXTRA-1:0]  extraReq = '0;
    logic [`IET_SEL_W-1:0]  srcSel [`IET_SHARED] = '{default: '0};
    iet_node_cfg_t          nodeCfg [`IET_NODES] = '{default: '0};
    logic [`IET_NODES-1:0]  swSetReq = '0;
    logic                   jumpCacheUse = 1'b1;
    logic [`IET_CHANS-1:0]  chanLoad = '0;
    iet_chan_t              chanLoadCfg = '0;
    logic [`IET_NODES-1:0]  requestFlagBit;
    logic                   cpuStall;
    logic                   moveValid;
    logic                   irqTake;
    logic                   busy;
    iet_move_t              move;
    logic [`IET_NODE_W-1:0] irqNode;
    iet_chan_t              chanState [`IET_CHANS];
    int                     stallCount;
    int                     mismatches = 0;
    int                     samples_checked = 0;
    int                     cycles = 0;

    iet_ctrl u_iet_ctrl (.clk_sys(clk_sys), .sys_rst(sys_rst), .hwReq(hwReq),
        .extraReq(extraReq), .srcSel(srcSel), .nodeCfg(nodeCfg), .swSetReq(swSetReq),
        .jumpCacheUse(jumpCacheUse), .chanLoad(chanLoad), .chanLoadCfg(chanLoadCfg),
        .requestFlagBit(requestFlagBit), .cpuStall(cpuStall), .moveValid(moveValid),
        .move(move), .irqTake(irqTake), .irqNode(irqNode), .chanState(chanState),
        .busy(busy));
    iet_src_model u_iet_src_model (.clk_sys(clk_sys), .cpuStall(cpuStall),
        .hwReq(hwReq), .stallCount(stallCount));

    always #12.5 clk_sys = ~clk_sys;
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Whole run needs about a hundred cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            mismatches++;
            summarize();
        end
    end
    // Cycles counted from the first cycle the flag is visible
    task automatic waitServe(output int n);
        n = 1;
        #1;
        while (!(irqTake === 1'b1 || moveValid === 1'b1) && n < 40) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask
    task automatic testLatency();
        int n;
        for (int c = 0; c < 2; c++) begin
            @(posedge clk_sys);
            jumpCacheUse <= c[0];
            if (c == 0) begin
                u_iet_src_model.fire(5);
            end else begin
                @(posedge clk_sys);
                swSetReq[5] <= 1'b1;
                @(posedge clk_sys);
                swSetReq[5] <= 1'b0;
            end
            #1;
            check(requestFlagBit[5], 1'b1);
            waitServe(n);
            check(n, c == 0 ? 12 : 8);
            check({irqTake, moveValid, irqNode}, {2'h2, 6'h05});
            @(posedge clk_sys);
            #1;
            check(requestFlagBit[5], 1'b0);
        end
    endtask
    task automatic testPriority();
        int n;
        @(posedge clk_sys);
        swSetReq <= 46'h0000000000E0;
        @(posedge clk_sys);
        swSetReq <= '0;
        waitServe(n);
        check(irqNode, 6'h07);
        @(posedge clk_sys);
        waitServe(n);
        check(irqNode, 6'h05);
        repeat (20) @(posedge clk_sys);
        #1;
        check({requestFlagBit[6], busy}, 2'h2);
    endtask
    task automatic loadChan(input iet_chan_t c);
        @(posedge clk_sys);
        chanLoadCfg <= c;
        chanLoad <= 8'h04;
        @(posedge clk_sys);
        chanLoad <= 8'h00;
        #1;
        check(chanState[2], c);
    endtask
    task automatic evtOnce(input logic [23:0] s, d, ns, nd, input logic w, irq,
                           input logic [7:0] cnt);
        int n;
        int st;
        st = stallCount;
        u_iet_src_model.fire(10);
        waitServe(n);
        check(n, 8);
        check({moveValid, cpuStall, irqTake}, {2'h3, irq});
        check(move, {s, d, w});
        @(posedge clk_sys);
        #1;
        check(cpuStall, 1'b0);
        check(stallCount - st, 1);
        check({chanState[2].src, chanState[2].dst}, {ns, nd});
        check(chanState[2].count, cnt);
    endtask
    task automatic testShared();
        int n;
        @(posedge clk_sys);
        srcSel[0] <= 3'h3;
        extraReq <= 8'h08;
        @(posedge clk_sys);
        extraReq <= 8'h00;
        #1;
        check(requestFlagBit[45:42], 4'h1);
        waitServe(n);
        check(irqNode, 6'h2A);
    endtask
    initial begin
        nodeCfg[5] = {1'b1, 4'h3, 1'b0, 3'h0};
        nodeCfg[6] = {1'b0, 4'hF, 1'b0, 3'h0};
        nodeCfg[7] = {1'b1, 4'h9, 1'b0, 3'h0};
        nodeCfg[10] = {1'b1, 4'h2, 1'b1, 3'h2};
        nodeCfg[42] = {1'b1, 4'h1, 1'b0, 3'h0};
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        testLatency();
        testPriority();
        loadChan({24'h001000, 24'h002000, 8'h02, 4'hA});
        evtOnce(24'h001000, 24'h002000, 24'h001002, 24'h002000, 1'b1, 1'b0, 8'h01);
        evtOnce(24'h001002, 24'h002000, 24'h001004, 24'h002000, 1'b1, 1'b1, 8'h00);
        // Continuous mode keeps the count
        loadChan({24'h003000, 24'h004000, 8'h05, 4'h5});
        evtOnce(24'h003000, 24'h004000, 24'h003000, 24'h004001, 1'b0, 1'b0, 8'h05);
        check(chanState[3], 60'h0);
        testShared();
        summarize();
    end
endmodule
